// ### bench/cgo_host_model.sv
/*
 host controller model: drives the plain register port of the colour bank.
 assumes one clock, slave never stalls, read data one cycle after the strobe.
*/
`timescale 1ns/1ps
module cgo_host_model (
    // clock
    input wire logic clk_i,
    // register port
    output logic [3:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [7:0] rdata_i
);
    initial begin
        addr_o = 4'h0;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // one-cycle write strobe, data inverted once released
    task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1 d = rdata_i;
    endtask
endmodule

// ### bench/testbench.sv
/*
 self-checking bench for the colour gain/offset register bank.
 assumes the host model drives the register port; bench drives the data path.
*/
`timescale 1ns/1ps
module testbench
    import cgo_pkg::*;
;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [3:0] addr, data_nibble;
    logic [7:0] wdata, rdata_o, offset_applied_o, gain_applied_o;
    logic wr, rd, output_test_select_o;
    logic [3:0] strobes, output_nibble_o;
    logic [1:0] colour_selection_o;
    logic [7:0] shadow [16];
    logic [7:0] got, ofs_exp, gain_exp;
    int failures = 0;
    int cmp_count = 0;

    always #12.5 clk_i = ~clk_i;

    cgo_host_model host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata_o));

    colour_gain_offset_regs dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata_o), .data_nibble_i(data_nibble),
        .internal_sample_strobe_i(strobes[3]), .video_sample_clk_i(strobes[2]),
        .converter_clk_i(strobes[1]), .reset_sample_clk_i(strobes[0]), .output_nibble_o(output_nibble_o),
        .offset_applied_o(offset_applied_o), .gain_applied_o(gain_applied_o),
        .colour_selection_o(colour_selection_o), .output_test_select_o(output_test_select_o));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // write through the host and keep the shadow copy in step
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        host.write_reg(a, d);
        if (a == OFS_OFFSET_ALL_COLOURS) begin
            for (int i = 1; i <= 3; i++) shadow[i] = d;
        end else if (a == OFS_GAIN_ALL_COLOURS) begin
            for (int i = 5; i <= 7; i++) shadow[i] = d;
        end else if (a == OFS_COLOUR_SELECT) begin
            shadow[a] = d & 8'h30;
        end else if (a < 4'h9) begin
            shadow[a] = d;
        end
    endtask

    task automatic rd_chk(input logic [3:0] a);
        host.read_reg(a, got);
        check(got, shadow[a]);
    endtask

    function automatic logic [3:0] nib_exp(input logic test, input logic [3:0] d, input logic [3:0] s);
        return test ? s : d;
    endfunction

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        final_report();
    end

    initial begin
        data_nibble = 4'h0;
        strobes = 4'h0;
        foreach (shadow[i]) shadow[i] = 8'h00;
        shadow[OFS_OFFSET_RED] = 8'h40;
        shadow[OFS_OFFSET_GREEN] = 8'h80;
        shadow[OFS_OFFSET_BLUE] = 8'h80;
        void'($urandom(32'hc215));
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check(offset_applied_o, 8'h40);
        check(gain_applied_o, 8'h00);
        check({7'h00, output_test_select_o}, 8'h00);
        for (int a = 0; a < 16; a++) rd_chk(a[3:0]);
        $display("reset values done");

        repeat (24) begin
            wr_reg(4'($urandom_range(0, 15)), 8'($urandom));
            rd_chk(4'($urandom_range(0, 15)));
        end
        $display("random access done");

        for (int k = 0; k < 8; k++) begin
            wr_reg(OFS_OFFSET_ALL_COLOURS, k[0] ? 8'hff : 8'($urandom));
            for (int a = 1; a <= 4; a++) rd_chk(a[3:0]);
            wr_reg(OFS_GAIN_ALL_COLOURS, k[0] ? 8'h00 : 8'($urandom));
            for (int a = 5; a <= 8; a++) rd_chk(a[3:0]);
        end
        $display("broadcast done");

        for (int s = 0; s < 4; s++) begin
            wr_reg(OFS_COLOUR_SELECT, {2'b00, s[1:0], 4'hf});
            if (s < 3) begin
                wr_reg(4'(1 + s), 8'($urandom));
                wr_reg(4'(5 + s), 8'($urandom));
                ofs_exp = shadow[1 + s];
                gain_exp = shadow[5 + s];
            end
            @(posedge clk_i);
            #1;
            check({6'h00, colour_selection_o}, {6'h00, s[1:0]});
            check(offset_applied_o, ofs_exp);
            check(gain_applied_o, gain_exp);
            rd_chk(OFS_COLOUR_SELECT);
        end
        $display("colour selection done");

        for (int t = 0; t < 2; t++) begin
            wr_reg(OFS_TEST_OUTPUT_CONTROL, {t[0], 7'($urandom)});
            rd_chk(OFS_TEST_OUTPUT_CONTROL);
            check({7'h00, output_test_select_o}, {7'h00, t[0]});
            repeat (16) begin
                @(posedge clk_i);
                data_nibble <= 4'($urandom);
                strobes <= 4'($urandom);
                @(posedge clk_i);
                #1;
                check({4'h0, output_nibble_o}, {4'h0, nib_exp(t[0], data_nibble, strobes)});
            end
        end
        $display("output test mode done");
        final_report();
    end
endmodule

// ### rtl/cgo_channel_mux.sv
/*
 picks the selected colour's offset and gain codes for the analogue channel.
 assumes selection 11 is never relied upon; it holds the last valid pick.
*/
`timescale 1ns/1ps
module cgo_channel_mux
    import cgo_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // codes in
    cgo_codes_if.dst codes,
    // applied codes
    output logic [7:0] offset_applied_o,
    output logic [7:0] gain_applied_o
);
    logic [7:0] off_d, off_q, gain_d, gain_q;

    always_comb begin
        off_d = off_q;
        gain_d = gain_q;
        case (codes.colour_selection)
            SEL_RED: begin
                off_d = codes.offset_code[0];
                gain_d = codes.gain_code[0];
            end
            SEL_GREEN: begin
                off_d = codes.offset_code[1];
                gain_d = codes.gain_code[1];
            end
            SEL_BLUE: begin
                off_d = codes.offset_code[2];
                gain_d = codes.gain_code[2];
            end
            default: begin
                off_d = off_q;
                gain_d = gain_q;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            off_q <= RST_OFFSET_RED;
            gain_q <= RST_GAIN;
        end else begin
            off_q <= off_d;
            gain_q <= gain_d;
        end
    end

    assign offset_applied_o = off_q;
    assign gain_applied_o = gain_q;

    green_pick_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        codes.colour_selection == SEL_GREEN |=> off_q == $past(codes.offset_code[1]))
        else $error("green offset not applied");
    blue_gain_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        codes.colour_selection == SEL_BLUE |=> gain_q == $past(codes.gain_code[2]))
        else $error("blue gain not applied");
endmodule

// ### rtl/cgo_test_out.sv
/*
 output nibble multiplexer: converted data or internal timing strobes.
 assumes strobes and data are on clk_i already.
*/
`timescale 1ns/1ps
module cgo_test_out (
    // mode
    input wire logic test_sel_i,
    // sources
    input wire logic [3:0] data_nibble_i,
    input wire logic internal_sample_strobe_i,
    input wire logic video_sample_clk_i,
    input wire logic converter_clk_i,
    input wire logic reset_sample_clk_i,
    // result
    output logic [3:0] nibble_o
);
    always_comb begin
        if (test_sel_i) begin
            nibble_o = {internal_sample_strobe_i, video_sample_clk_i, converter_clk_i, reset_sample_clk_i};
        end else begin
            nibble_o = data_nibble_i;
        end
    end
endmodule

// ### rtl/colour_gain_offset_regs.sv
/*
 register bank for colour offset/gain codes, colour selection and output test mode.
 assumes a plain register port master on clk_i; pin-side strobes arrive on clk_i.
*/
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - test bit clear: nibble carries converted data
// - test bit 7 set: timing signals on nibble
// - nibble 3..0: strobe, video, converter, reset clocks
// - red offset held, applied when red selected
// - green offset resets mid-scale, applied for green
// - blue offset resets mid-scale, applied for blue
// - broadcast offset write sets all three
// - broadcast gain write sets all three
// - red gain code applied when red selected
// - green gain code applied when green selected
// - blue gain code applied when blue selected
// - selection: 00 red, 01 green, 10 blue
module colour_gain_offset_regs
    import cgo_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // data path and internal timing
    input wire logic [3:0] data_nibble_i,
    input wire logic internal_sample_strobe_i,
    input wire logic video_sample_clk_i,
    input wire logic converter_clk_i,
    input wire logic reset_sample_clk_i,
    // channel outputs
    output logic [3:0] output_nibble_o,
    output logic [7:0] offset_applied_o,
    output logic [7:0] gain_applied_o,
    output logic [1:0] colour_selection_o,
    output logic output_test_select_o
);
    cgo_codes_if codes ();

    logic [7:0] test_d, test_q;
    logic [7:0] off_d [3];
    logic [7:0] off_q [3];
    logic [7:0] gain_d [3];
    logic [7:0] gain_q [3];
    logic [1:0] sel_d, sel_q;
    logic [7:0] rdata_d, rdata_q;
    logic [3:0] nib_d, nib_q;
    logic output_test_select;

    assign output_test_select = test_q[POS_OUTPUT_TEST_SELECT];

    // register writes
    always_comb begin
        test_d = test_q;
        sel_d = sel_q;
        for (int c = 0; c < NUM_COLOURS; c++) begin
            off_d[c] = off_q[c];
            gain_d[c] = gain_q[c];
        end
        if (wr_i) begin
            if (addr_i == OFS_TEST_OUTPUT_CONTROL) begin
                test_d = wdata_i;
            end else if (addr_i == OFS_OFFSET_RED) begin
                off_d[0] = wdata_i;
            end else if (addr_i == OFS_OFFSET_GREEN) begin
                off_d[1] = wdata_i;
            end else if (addr_i == OFS_OFFSET_BLUE) begin
                off_d[2] = wdata_i;
            end else if (addr_i == OFS_OFFSET_ALL_COLOURS) begin
                for (int c = 0; c < NUM_COLOURS; c++) begin
                    off_d[c] = wdata_i;
                end
            end else if (addr_i == OFS_GAIN_RED) begin
                gain_d[0] = wdata_i;
            end else if (addr_i == OFS_GAIN_GREEN) begin
                gain_d[1] = wdata_i;
            end else if (addr_i == OFS_GAIN_BLUE) begin
                gain_d[2] = wdata_i;
            end else if (addr_i == OFS_GAIN_ALL_COLOURS) begin
                for (int c = 0; c < NUM_COLOURS; c++) begin
                    gain_d[c] = wdata_i;
                end
            end else if (addr_i == OFS_COLOUR_SELECT) begin
                sel_d = wdata_i[POS_COLOUR_SEL_LO +: 2];
            end
        end
    end

    // read data, one cycle later; broadcast and unmapped read zero
    always_comb begin
        rdata_d = 8'h00;
        if (rd_i) begin
            if (addr_i == OFS_TEST_OUTPUT_CONTROL) begin
                rdata_d = test_q;
            end else if (addr_i == OFS_OFFSET_RED) begin
                rdata_d = off_q[0];
            end else if (addr_i == OFS_OFFSET_GREEN) begin
                rdata_d = off_q[1];
            end else if (addr_i == OFS_OFFSET_BLUE) begin
                rdata_d = off_q[2];
            end else if (addr_i == OFS_GAIN_RED) begin
                rdata_d = gain_q[0];
            end else if (addr_i == OFS_GAIN_GREEN) begin
                rdata_d = gain_q[1];
            end else if (addr_i == OFS_GAIN_BLUE) begin
                rdata_d = gain_q[2];
            end else if (addr_i == OFS_COLOUR_SELECT) begin
                rdata_d = {2'h0, sel_q, 4'h0};
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            test_q <= RST_TEST_OUTPUT_CONTROL;
            sel_q <= RST_COLOUR_SEL;
            off_q[0] <= RST_OFFSET_RED;
            off_q[1] <= RST_OFFSET_GREEN;
            off_q[2] <= RST_OFFSET_BLUE;
            for (int c = 0; c < NUM_COLOURS; c++) begin
                gain_q[c] <= RST_GAIN;
            end
        end else begin
            test_q <= test_d;
            sel_q <= sel_d;
            for (int c = 0; c < NUM_COLOURS; c++) begin
                off_q[c] <= off_d[c];
                gain_q[c] <= gain_d[c];
            end
        end
    end

    // read data register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // codes to the channel mux
    genvar g;
    generate
        for (g = 0; g < NUM_COLOURS; g++) begin : g_codes
            assign codes.offset_code[g] = off_q[g];
            assign codes.gain_code[g] = gain_q[g];
        end
    endgenerate
    assign codes.colour_selection = sel_q;

    cgo_channel_mux u_mux (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .codes(codes),
        .offset_applied_o(offset_applied_o),
        .gain_applied_o(gain_applied_o)
    );

    cgo_test_out u_tout (
        .test_sel_i(output_test_select),
        .data_nibble_i(data_nibble_i),
        .internal_sample_strobe_i(internal_sample_strobe_i),
        .video_sample_clk_i(video_sample_clk_i),
        .converter_clk_i(converter_clk_i),
        .reset_sample_clk_i(reset_sample_clk_i),
        .nibble_o(nib_d)
    );

    // output nibble registered
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            nib_q <= 4'h0;
        end else begin
            nib_q <= nib_d;
        end
    end

    assign output_nibble_o = nib_q;
    assign rdata_o = rdata_q;
    assign colour_selection_o = sel_q;
    assign output_test_select_o = test_q[POS_OUTPUT_TEST_SELECT];

    sequence bcast_off_wr_s;
        wr_i && addr_i == OFS_OFFSET_ALL_COLOURS;
    endsequence
    sequence bcast_gain_wr_s;
        wr_i && addr_i == OFS_GAIN_ALL_COLOURS;
    endsequence
    sequence off_red_wr_s;
        wr_i && addr_i == OFS_OFFSET_RED;
    endsequence
    sequence off_green_wr_s;
        wr_i && addr_i == OFS_OFFSET_GREEN;
    endsequence
    sequence off_blue_wr_s;
        wr_i && addr_i == OFS_OFFSET_BLUE;
    endsequence
    sequence gain_red_wr_s;
        wr_i && addr_i == OFS_GAIN_RED;
    endsequence
    sequence gain_green_wr_s;
        wr_i && addr_i == OFS_GAIN_GREEN;
    endsequence
    sequence gain_blue_wr_s;
        wr_i && addr_i == OFS_GAIN_BLUE;
    endsequence
    sequence test_wr_s;
        wr_i && addr_i == OFS_TEST_OUTPUT_CONTROL;
    endsequence
    sequence sel_rd_s;
        rd_i && addr_i == OFS_COLOUR_SELECT;
    endsequence
    sequence green_held_s;
        sel_q == SEL_GREEN ##1 sel_q == SEL_GREEN;
    endsequence
    sequence blue_held_s;
        sel_q == SEL_BLUE ##1 sel_q == SEL_BLUE;
    endsequence

    // broadcast writes
    offset_broadcast_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        bcast_off_wr_s |=> off_q[0] == $past(wdata_i) && off_q[1] == $past(wdata_i)
            && off_q[2] == $past(wdata_i))
        else $error("offset broadcast missed a colour");
    gain_broadcast_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        bcast_gain_wr_s |=> gain_q[0] == $past(wdata_i) && gain_q[1] == $past(wdata_i)
            && gain_q[2] == $past(wdata_i))
        else $error("gain broadcast missed a colour");

    // output nibble and test mode
    normal_data_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !output_test_select |=> output_nibble_o == $past(data_nibble_i))
        else $error("nibble not data in normal mode");
    test_enter_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_i && addr_i == OFS_TEST_OUTPUT_CONTROL && wdata_i[POS_OUTPUT_TEST_SELECT] |=> output_test_select_o)
        else $error("test mode not entered");
    test_store_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        test_wr_s |=> output_test_select_o == $past(wdata_i[POS_OUTPUT_TEST_SELECT]))
        else $error("test select not stored");
    test_nibble_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        output_test_select |=> output_nibble_o == {$past(internal_sample_strobe_i),
            $past(video_sample_clk_i), $past(converter_clk_i), $past(reset_sample_clk_i)})
        else $error("test nibble order wrong");

    // applied codes per colour
    red_apply_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        sel_q == SEL_RED ##1 sel_q == SEL_RED |-> offset_applied_o == $past(off_q[0])
            && gain_applied_o == $past(gain_q[0]))
        else $error("red codes not applied");
    green_apply_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        green_held_s |-> offset_applied_o == $past(off_q[1]) && gain_applied_o == $past(gain_q[1]))
        else $error("green codes not applied");
    blue_apply_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        blue_held_s |-> offset_applied_o == $past(off_q[2]) && gain_applied_o == $past(gain_q[2]))
        else $error("blue codes not applied");
    green_gain_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        sel_q == SEL_GREEN |=> gain_applied_o == $past(gain_q[1]))
        else $error("green gain not applied");
    blue_offset_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        sel_q == SEL_BLUE |=> offset_applied_o == $past(off_q[2]))
        else $error("blue offset not applied");
    red_gain_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        sel_q == SEL_RED |=> gain_applied_o == $past(gain_q[0]))
        else $error("red gain not applied");
    reserved_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        sel_q == 2'h3 |=> offset_applied_o == $past(offset_applied_o)
            && gain_applied_o == $past(gain_applied_o))
        else $error("reserved selection changed codes");

    // colour selection
    sel_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_i && addr_i == OFS_COLOUR_SELECT
            |=> colour_selection_o == $past(wdata_i[POS_COLOUR_SEL_LO +: 2]))
        else $error("colour selection not stored");
    sel_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        sel_rd_s |=> rdata_o == {2'h0, $past(sel_q), 4'h0})
        else $error("colour selection read wrong");

    // single register writes and reads
    red_offset_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        off_red_wr_s |=> off_q[0] == $past(wdata_i))
        else $error("red offset write lost");
    green_offset_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        off_green_wr_s |=> off_q[1] == $past(wdata_i))
        else $error("green offset write lost");
    blue_offset_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        off_blue_wr_s |=> off_q[2] == $past(wdata_i))
        else $error("blue offset write lost");
    red_gain_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        gain_red_wr_s |=> gain_q[0] == $past(wdata_i))
        else $error("red gain write lost");
    green_gain_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        gain_green_wr_s |=> gain_q[1] == $past(wdata_i))
        else $error("green gain write lost");
    blue_gain_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        gain_blue_wr_s |=> gain_q[2] == $past(wdata_i))
        else $error("blue gain write lost");
    green_offset_rd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_i && addr_i == OFS_OFFSET_GREEN |=> rdata_o == $past(off_q[1]))
        else $error("green offset read wrong");
    blue_gain_rd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_i && addr_i == OFS_GAIN_BLUE |=> rdata_o == $past(gain_q[2]))
        else $error("blue gain read wrong");
endmodule

// ### shared/cgo_codes_if.sv
/*
 interface carrying the per-colour codes and selection to the channel mux.
 assumes one clock domain.
*/
`timescale 1ns/1ps
interface cgo_codes_if;
    logic [7:0] offset_code [3];
    logic [7:0] gain_code [3];
    logic [1:0] colour_selection;
    modport src (output offset_code, output gain_code, output colour_selection);
    modport dst (input offset_code, input gain_code, input colour_selection);
endinterface

// ### shared/cgo_pkg.sv
/*
 colour gain/offset register bank: offsets, reset values, field positions.
 assumes a plain register port with 8-bit data and one-cycle read latency.
*/
package cgo_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [3:0] OFS_TEST_OUTPUT_CONTROL = 4'h0;
    localparam logic [3:0] OFS_OFFSET_RED = 4'h1;
    localparam logic [3:0] OFS_OFFSET_GREEN = 4'h2;
    localparam logic [3:0] OFS_OFFSET_BLUE = 4'h3;
    localparam logic [3:0] OFS_OFFSET_ALL_COLOURS = 4'h4;
    localparam logic [3:0] OFS_GAIN_RED = 4'h5;
    localparam logic [3:0] OFS_GAIN_GREEN = 4'h6;
    localparam logic [3:0] OFS_GAIN_BLUE = 4'h7;
    localparam logic [3:0] OFS_GAIN_ALL_COLOURS = 4'h8;
    localparam logic [3:0] OFS_COLOUR_SELECT = 4'h9;
    // field positions
    localparam int POS_OUTPUT_TEST_SELECT = 7;
    localparam int POS_COLOUR_SEL_LO = 4;
    // reset values
    localparam logic [7:0] RST_TEST_OUTPUT_CONTROL = 8'h00;
    localparam logic [7:0] RST_OFFSET_RED = 8'h40;
    localparam logic [7:0] RST_OFFSET_GREEN = 8'h80;
    localparam logic [7:0] RST_OFFSET_BLUE = 8'h80;
    localparam logic [7:0] RST_GAIN = 8'h00;
    localparam logic [1:0] RST_COLOUR_SEL = 2'h0;
    // colour selection encoding
    localparam logic [1:0] SEL_RED = 2'h0;
    localparam logic [1:0] SEL_GREEN = 2'h1;
    localparam logic [1:0] SEL_BLUE = 2'h2;
    localparam int NUM_COLOURS = 3;
endpackage
